// ==== common/bcc_regs.svh ====
// register map, field positions, reset values and divider counts of the calendar clock
// assumes byte addresses on a 32-bit register bus, one register per word
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

// register byte offsets
`define BCC_OFF_DIV      8'h00
`define BCC_OFF_SEC      8'h04
`define BCC_OFF_MIN      8'h08
`define BCC_OFF_HOUR     8'h0c
`define BCC_OFF_WDAY     8'h10
`define BCC_OFF_DATE     8'h14
`define BCC_OFF_MONTH    8'h18
`define BCC_OFF_YEAR     8'h1c
`define BCC_OFF_ALM_BASE 8'h20
`define BCC_OFF_FLAG     8'h38
`define BCC_OFF_RUN      8'h3c
`define BCC_ALM_STRIDE   8'h04

// writable bits of the counters and alarm value fields
`define BCC_MASK_SEC     7'h7f
`define BCC_MASK_MIN     7'h7f
`define BCC_MASK_HOUR    7'h3f
`define BCC_MASK_WDAY    7'h07
`define BCC_MASK_DATE    7'h3f
`define BCC_MASK_MONTH   7'h1f

// flag_control bit positions
`define BCC_FC_CARRY     7
`define BCC_FC_CIE       4
`define BCC_FC_AIE       3
`define BCC_FC_ALARM     0

// run_control bit positions and power-on value
`define BCC_RC_PFLAG     7
`define BCC_RC_PSEL_HI   6
`define BCC_RC_PSEL_LO   4
`define BCC_RC_OSC       3
`define BCC_RC_ADJ       2
`define BCC_RC_DIVRST    1
`define BCC_RC_START     0
`define BCC_RUN_RESET    8'h09

// crystal ticks per second, divider wrap, alarm enable position
`define BCC_XTAL_HZ      32768
`define BCC_DIV_LAST     15'h7fff
`define BCC_ALM_EN       7

// bus responses
`define BCC_RESP_OKAY    2'h0
`define BCC_RESP_DECERR  2'h3

`endif

// ==== common/bcc_pkg.sv ====
// types used by the calendar clock design; its bench uses none of them
// assumes the register header is used alongside for numbers
package bcc_pkg;
  typedef logic [7:0] bcc_byte_t;

  // periodic interrupt period codes
  typedef enum logic [2:0] {
    BCC_PER_OFF   = 3'h0,
    BCC_PER_256TH = 3'h1,
    BCC_PER_64TH  = 3'h2,
    BCC_PER_16TH  = 3'h3,
    BCC_PER_4TH   = 3'h4,
    BCC_PER_HALF  = 3'h5,
    BCC_PER_1S    = 3'h6,
    BCC_PER_2S    = 3'h7
  } bcc_period_t;
endpackage

// ==== rtl/bcc_calendar_clock.sv ====
// calendar clock with alarm, periodic and carry flags behind an AXI4-Lite slave
// assumes a free-running crystal square wave on crystalIn, far slower than clock
//
// Functional notes
// - divider chain runs only from the dedicated 32.768 kHz crystal ticks
// - divider_state is 8-bit read-only, bit 7 zero, bits 6..0 show 1Hz..64Hz
// - writing 1 to divider reset or thirty-second adjust zeroes the divider
// - divider and calendar counters are never initialised by power-on or manual reset
// - seconds advance on divider carry, BCD 00..59, bit 7 reads zero
// - minutes advance on seconds carry, BCD 00..59, bit 7 reads zero
// - hours advance on minutes carry, BCD 00..23, bits 7..6 read zero
// - weekday counts 0..6 in bits 2..0 on each day carry
// - date advances on day carry from 01 to month and leap maximum
// - month advances on date carry, 1..12, bits 7..5 read zero
// - year holds two BCD digits 00..99, advancing on month carry
// - year divisible by 4 is leap, giving February 29 days
// - alarm bit 7 enables comparison of that field only
// - alarm raised when every enabled field equals its counter
// - power-on reset clears alarm enables; alarm value fields keep their contents
// - seconds alarm holds tens in bits 6..4 and units in bits 3..0
// - periodic flag with period 1/256 to 2 seconds selectable
// - carry interrupt tells software a counter moved during its read
// - clock output can drive the pin shared with the timer unit
// - carry flag sets on divider or seconds step; cleared by writing 0
// - alarm flag sets on match, write 0 clears, write 1 keeps; request gated by enable
// - run_control resets to 09; manual reset spares oscillator enable and start
`timescale 1ns/1ps
`include "bcc_regs.svh"

module bcc_calendar_clock (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        manualReset,
  // crystal and shared pin
  input  wire logic        crystalIn,
  input  wire logic        rtcOutSelect,
  output logic             sharedTimerClockPinOut,
  output logic             sharedTimerClockPinOe,
  // interrupt requests
  output logic             carryIrq,
  output logic             alarmIrq,
  output logic             periodicIrq,
  // axi4-lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // bcd increment: {wrap, next}
  function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] maxV,
                                         input logic [7:0] minV);
    if (v == maxV)
      bcdStep = {1'b1, minV};
    else if (v[3:0] == 4'h9)
      bcdStep = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      bcdStep = {1'b0, v + 8'h01};
  endfunction

  function automatic logic isLeap(input logic [7:0] y);
    isLeap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] lastDate(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:   lastDate = isLeap(y) ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   lastDate = 8'h30;
      default: lastDate = 8'h31;
    endcase
  endfunction

  function automatic logic regKnown(input logic [7:0] a);
    regKnown = (a[1:0] == 2'h0) && (a <= `BCC_OFF_RUN);
  endfunction

  localparam logic [6:0] ALM_MASK [6] = '{`BCC_MASK_SEC, `BCC_MASK_MIN, `BCC_MASK_HOUR,
                                          `BCC_MASK_WDAY, `BCC_MASK_DATE, `BCC_MASK_MONTH};

  // crystal synchroniser and tick
  logic        crys1;
  logic        crys2;
  logic        crys3;
  logic        xtalTick;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      crys1 <= 1'b0;
      crys2 <= 1'b0;
      crys3 <= 1'b0;
    end else begin
      crys1 <= crystalIn;
      crys2 <= crys1;
      crys3 <= crys2;
    end
  end
  assign xtalTick = crys2 & ~crys3;

  // shared pin drive
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sharedTimerClockPinOut <= 1'b0;
      sharedTimerClockPinOe  <= 1'b0;
    end else begin
      sharedTimerClockPinOut <= crys3;
      sharedTimerClockPinOe  <= rtcOutSelect;
    end
  end

  // bus write side
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  wrAddr;
  logic [7:0]  wrByte;
  logic        wrLane;
  logic        regWrite;

  assign awready  = ~awHeld;
  assign wready   = ~wHeld;
  assign regWrite = awHeld & wHeld & ~bvalid;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      wrAddr <= 8'h00;
      wrByte <= 8'h00;
      wrLane <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= `BCC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        wrAddr <= awaddr;
      end else if (regWrite) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wrByte <= wdata[7:0];
        wrLane <= wstrb[0];
      end else if (regWrite) begin
        wHeld <= 1'b0;
      end
      if (regWrite) begin
        bvalid <= 1'b1;
        bresp  <= regKnown(wrAddr) ? `BCC_RESP_OKAY : `BCC_RESP_DECERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wrEn(input logic [7:0] a);
    wrEn = regWrite && wrLane && (wrAddr == a);
  endfunction

  // control registers
  logic        rcFlag;
  logic [2:0]  rcSelect;
  logic        rcOsc;
  logic        rcStart;
  logic        carryFlag;
  logic        carryIe;
  logic        alarmIe;
  logic        alarmFlag;
  logic        wrRun;
  logic        wrFlag;
  logic        adjWrite;
  logic        divClear;
  logic        periodHit;
  logic        divStep;
  logic        secInc;
  logic        alarmRise;

  assign wrRun    = regWrite && wrLane && (wrAddr == `BCC_OFF_RUN);
  assign wrFlag   = regWrite && wrLane && (wrAddr == `BCC_OFF_FLAG);
  assign adjWrite = wrRun && wrByte[`BCC_RC_ADJ];
  assign divClear = wrRun && (wrByte[`BCC_RC_ADJ] || wrByte[`BCC_RC_DIVRST]);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rcFlag   <= 1'(`BCC_RUN_RESET >> `BCC_RC_PFLAG);
      rcSelect <= 3'(`BCC_RUN_RESET >> `BCC_RC_PSEL_LO);
      rcOsc    <= 1'(`BCC_RUN_RESET >> `BCC_RC_OSC);
      rcStart  <= 1'(`BCC_RUN_RESET >> `BCC_RC_START);
    end else if (manualReset) begin
      rcFlag   <= 1'b0;
      rcSelect <= 3'(`BCC_RUN_RESET >> `BCC_RC_PSEL_LO);
    end else begin
      if (wrRun) begin
        rcSelect <= wrByte[`BCC_RC_PSEL_HI:`BCC_RC_PSEL_LO];
        rcOsc    <= wrByte[`BCC_RC_OSC];
        rcStart  <= wrByte[`BCC_RC_START];
      end
      if (periodHit)
        rcFlag <= 1'b1;
      else if (wrRun && !wrByte[`BCC_RC_PFLAG])
        rcFlag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      carryFlag <= 1'b0;
      carryIe   <= 1'b0;
      alarmIe   <= 1'b0;
      alarmFlag <= 1'b0;
    end else if (manualReset) begin
      carryIe   <= 1'b0;
      alarmIe   <= 1'b0;
      alarmFlag <= 1'b0;
    end else begin
      if (wrFlag) begin
        carryIe <= wrByte[`BCC_FC_CIE];
        alarmIe <= wrByte[`BCC_FC_AIE];
      end
      if (divStep || secInc || (wrFlag && wrByte[`BCC_FC_CARRY]))
        carryFlag <= 1'b1;
      else if (wrFlag)
        carryFlag <= 1'b0;
      if (alarmRise)
        alarmFlag <= 1'b1;
      else if (wrFlag && !wrByte[`BCC_FC_ALARM])
        alarmFlag <= 1'b0;
    end
  end

  assign carryIrq    = carryFlag & carryIe;
  assign alarmIrq    = alarmFlag & alarmIe;
  assign periodicIrq = rcFlag;

  // divider and calendar counters, no reset
  logic [14:0] divCount;
  logic [7:0]  secCount;
  logic [7:0]  minCount;
  logic [7:0]  hourCount;
  logic [2:0]  wdayCount;
  logic [7:0]  dateCount;
  logic [7:0]  monthCount;
  logic [7:0]  yearCount;
  logic        advance;
  logic        divWrap;
  logic        minInc;
  logic        hourInc;
  logic        dayInc;
  logic        monthInc;
  logic        yearInc;
  logic [8:0]  secNext;
  logic [8:0]  minNext;
  logic [8:0]  hourNext;
  logic [8:0]  dateNext;
  logic [8:0]  monthNext;
  logic [8:0]  yearNext;

  assign advance   = xtalTick && rcOsc && rcStart;
  assign divWrap   = advance && (divCount == `BCC_DIV_LAST);
  assign divStep   = advance && (divCount[7:0] == 8'hff);
  assign secNext   = bcdStep(secCount, 8'h59, 8'h00);
  assign minNext   = bcdStep(minCount, 8'h59, 8'h00);
  assign hourNext  = bcdStep(hourCount, 8'h23, 8'h00);
  assign dateNext  = bcdStep(dateCount, lastDate(monthCount, yearCount), 8'h01);
  assign monthNext = bcdStep(monthCount, 8'h12, 8'h01);
  assign yearNext  = bcdStep(yearCount, 8'h99, 8'h00);
  assign secInc    = divWrap;
  assign minInc    = (secInc && secNext[8]) || (adjWrite && secCount >= 8'h30);
  assign hourInc   = minInc && minNext[8];
  assign dayInc    = hourInc && hourNext[8];
  assign monthInc  = dayInc && dateNext[8];
  assign yearInc   = monthInc && monthNext[8];

  always_ff @(posedge clock) begin
    if (divClear)
      divCount <= 15'h0000;
    else if (advance)
      divCount <= divCount + 15'h0001;
    if (adjWrite)
      secCount <= 8'h00;
    else if (wrEn(`BCC_OFF_SEC))
      secCount <= {1'b0, wrByte[6:0] & `BCC_MASK_SEC};
    else if (secInc)
      secCount <= secNext[7:0];
    if (wrEn(`BCC_OFF_MIN))
      minCount <= {1'b0, wrByte[6:0] & `BCC_MASK_MIN};
    else if (minInc)
      minCount <= minNext[7:0];
    if (wrEn(`BCC_OFF_HOUR))
      hourCount <= {1'b0, wrByte[6:0] & `BCC_MASK_HOUR};
    else if (hourInc)
      hourCount <= hourNext[7:0];
    if (wrEn(`BCC_OFF_WDAY))
      wdayCount <= wrByte[2:0];
    else if (dayInc)
      wdayCount <= (wdayCount == 3'h6) ? 3'h0 : wdayCount + 3'h1;
    if (wrEn(`BCC_OFF_DATE))
      dateCount <= {1'b0, wrByte[6:0] & `BCC_MASK_DATE};
    else if (dayInc)
      dateCount <= dateNext[7:0];
    if (wrEn(`BCC_OFF_MONTH))
      monthCount <= {1'b0, wrByte[6:0] & `BCC_MASK_MONTH};
    else if (monthInc)
      monthCount <= monthNext[7:0];
    if (wrEn(`BCC_OFF_YEAR))
      yearCount <= wrByte;
    else if (yearInc)
      yearCount <= yearNext[7:0];
  end

  // periodic event select
  always_comb begin
    case (bcc_pkg::bcc_period_t'(rcSelect))
      bcc_pkg::BCC_PER_256TH: periodHit = advance && (divCount[6:0] == 7'h7f);
      bcc_pkg::BCC_PER_64TH:  periodHit = advance && (divCount[8:0] == 9'h1ff);
      bcc_pkg::BCC_PER_16TH:  periodHit = advance && (divCount[10:0] == 11'h7ff);
      bcc_pkg::BCC_PER_4TH:   periodHit = advance && (divCount[12:0] == 13'h1fff);
      bcc_pkg::BCC_PER_HALF:  periodHit = advance && (divCount[13:0] == 14'h3fff);
      bcc_pkg::BCC_PER_1S:    periodHit = divWrap;
      bcc_pkg::BCC_PER_2S:    periodHit = divWrap && secCount[0];
      default:                periodHit = 1'b0;
    endcase
  end

  // alarm registers and compare
  logic [5:0]  almEnable;
  logic [6:0]  almValue [6];
  logic [6:0]  cntView  [6];
  logic [5:0]  fieldHit;
  logic        alarmMatch;
  logic        alarmMatchPrev;

  assign cntView[0] = secCount[6:0];
  assign cntView[1] = minCount[6:0];
  assign cntView[2] = hourCount[6:0];
  assign cntView[3] = {4'h0, wdayCount};
  assign cntView[4] = dateCount[6:0];
  assign cntView[5] = monthCount[6:0];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      almEnable      <= 6'h00;
      alarmMatchPrev <= 1'b0;
    end else begin
      alarmMatchPrev <= alarmMatch;
      for (int i = 0; i < 6; i++) begin
        if (wrEn(8'(`BCC_OFF_ALM_BASE + `BCC_ALM_STRIDE * i)))
          almEnable[i] <= wrByte[`BCC_ALM_EN];
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < 6; i++) begin
      if (wrEn(8'(`BCC_OFF_ALM_BASE + `BCC_ALM_STRIDE * i)))
        almValue[i] <= wrByte[6:0] & ALM_MASK[i];
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++)
      fieldHit[i] = !almEnable[i] || (almValue[i] == cntView[i]);
  end
  assign alarmMatch = (|almEnable) && (&fieldHit);
  assign alarmRise  = alarmMatch && !alarmMatchPrev;

  // bus read side
  logic [7:0]  readByte;
  logic [7:0]  alarmIdx;

  assign arready  = ~rvalid;
  assign alarmIdx = (araddr - `BCC_OFF_ALM_BASE) >> 2;

  always_comb begin
    readByte = 8'h00;
    case (araddr)
      `BCC_OFF_DIV:   readByte = {1'b0, divCount[14:8]};
      `BCC_OFF_SEC:   readByte = secCount;
      `BCC_OFF_MIN:   readByte = minCount;
      `BCC_OFF_HOUR:  readByte = hourCount;
      `BCC_OFF_WDAY:  readByte = {5'h00, wdayCount};
      `BCC_OFF_DATE:  readByte = dateCount;
      `BCC_OFF_MONTH: readByte = monthCount;
      `BCC_OFF_YEAR:  readByte = yearCount;
      `BCC_OFF_FLAG:  readByte = {carryFlag, 2'h0, carryIe, alarmIe, 2'h0, alarmFlag};
      `BCC_OFF_RUN:   readByte = {rcFlag, rcSelect, rcOsc, 2'h0, rcStart};
      default: begin
        if (regKnown(araddr) && araddr >= `BCC_OFF_ALM_BASE)
          readByte = {almEnable[alarmIdx[2:0]], almValue[alarmIdx[2:0]]};
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `BCC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, readByte};
      rresp  <= regKnown(araddr) ? `BCC_RESP_OKAY : `BCC_RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_div_clear_write: assert property (divClear |=> divCount == 15'h0000)
    else $error("divider not cleared by control write");
  a_sec_wrap_carry: assert property (
    secInc && !regWrite && secCount == 8'h59 |=> secCount == 8'h00)
    else $error("seconds did not wrap to 00");
  a_min_follow_sec: assert property (
    minInc && minCount == 8'h59 && (!regWrite || wrAddr == `BCC_OFF_RUN)
    |=> minCount == 8'h00 && $changed(hourCount))
    else $error("minute wrap did not carry into the hour");
  a_hour_wrap_day: assert property (
    hourInc && hourCount == 8'h23 && (!regWrite || wrAddr == `BCC_OFF_RUN)
    |=> hourCount == 8'h00 && $changed(wdayCount))
    else $error("hour wrap did not advance the day");
  a_leap_feb_date: assert property (
    dayInc && (!regWrite || wrAddr == `BCC_OFF_RUN) && monthCount == 8'h02
    && dateCount == 8'h28 && isLeap(yearCount) |=> dateCount == 8'h29)
    else $error("leap february ended at 28");
  a_alarm_enb_gate: assert property (almEnable == 6'h00 |-> !alarmMatch)
    else $error("alarm match with no field enabled");
  a_alarm_flag_set: assert property (alarmRise && !manualReset |=> alarmFlag ##1 alarmFlag)
    else $error("alarm flag missed or lost the match");
  a_carry_flag_set: assert property ((divStep || secInc) && !manualReset |=> carryFlag)
    else $error("carry flag not set on counter step");
  a_adjust_minute: assert property (
    adjWrite && secCount >= 8'h30 |=> secCount == 8'h00 && $changed(minCount))
    else $error("adjust did not carry a minute");
  a_stop_freezes: assert property (
    !rcStart && !regWrite |=> $stable(divCount) && $stable(secCount))
    else $error("counters moved while stopped");

  c_alarm_hit:     cover property (alarmRise ##1 alarmFlag);
  c_periodic_flag: cover property ($rose(rcFlag));
  c_year_wrap:     cover property (yearInc && yearCount == 8'h99);

endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the calendar clock, driving its axi4-lite slave directly
// assumes the register header and package are compiled ahead of this file
`timescale 1ns/1ps
`include "bcc_regs.svh"
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module tb_top;
  logic        clock        = 1'b0;
  logic        reset_n      = 1'b0;
  logic        manualReset  = 1'b0;
  logic        crystalIn    = 1'b0;
  logic        rtcOutSelect = 1'b0;
  logic [7:0]  awaddr       = 8'h00;
  logic [7:0]  araddr       = 8'h00;
  logic [31:0] wdata        = 32'h0;
  logic [3:0]  wstrb        = 4'hf;
  logic        awvalid      = 1'b0;
  logic        wvalid       = 1'b0;
  logic        bready       = 1'b0;
  logic        arvalid      = 1'b0;
  logic        rready       = 1'b0;
  logic        pinOut, pinOe, carryIrq, alarmIrq, periodicIrq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [1:0]  seen;
  logic [31:0] rdata, rd;
  int          miscompares  = 0;
  int          nChecks      = 0;
  int          cycles       = 0;

  // counter and alarm readback masks, offsets 04 to 34
  localparam logic [7:0] MASKS [13] = '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff,
                                        8'hff, 8'hff, 8'hbf, 8'h87, 8'hbf, 8'h9f};
  // seconds..year loaded, then minutes..year expected after a thirty-second adjust
  localparam logic [7:0] CAL [6][13] = '{
    '{8'h29, 8'h10, 8'h05, 8'h02, 8'h30, 8'h04, 8'h00, 8'h10, 8'h05, 8'h02, 8'h30, 8'h04, 8'h00},
    '{8'h45, 8'h59, 8'h23, 8'h06, 8'h28, 8'h02, 8'h24, 8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h24},
    '{8'h30, 8'h59, 8'h23, 8'h00, 8'h29, 8'h02, 8'h24, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h24},
    '{8'h45, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h23, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h23},
    '{8'h45, 8'h59, 8'h23, 8'h01, 8'h30, 8'h04, 8'h21, 8'h00, 8'h00, 8'h02, 8'h01, 8'h05, 8'h21},
    '{8'h59, 8'h59, 8'h23, 8'h05, 8'h31, 8'h12, 8'h99, 8'h00, 8'h00, 8'h06, 8'h01, 8'h01, 8'h00}};

  always #5 clock = ~clock;
  // free-running crystal, phase unrelated to the system clock
  always #43 crystalIn = ~crystalIn;

  bcc_calendar_clock DUT (
    .clock, .reset_n, .manualReset, .crystalIn, .rtcOutSelect,
    .sharedTimerClockPinOut(pinOut), .sharedTimerClockPinOe(pinOe),
    .carryIrq, .alarmIrq, .periodicIrq,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit awDone = 0;
    bit wDone  = 0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && awready) begin
        awDone = 1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    `CHK("write response", `BCC_RESP_OKAY, resp)
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    rdr(a);
    `CHK(nm, {24'h0, e}, rd)
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      giveVerdict();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rc(`BCC_OFF_RUN, `BCC_RUN_RESET, "run control power-on value");
    // give divider and seconds a known value before the first stop
    wc(`BCC_OFF_RUN, 8'h0b);
    wc(`BCC_OFF_SEC, 8'h00);
    wc(`BCC_OFF_RUN, 8'h08);
    rdr(`BCC_OFF_FLAG);
    `CHK("flag control enables", 8'h00, rd[7:0] & 8'h19)
    for (int i = 0; i < 6; i++) begin
      rdr(`BCC_OFF_ALM_BASE + 8'(4 * i));
      `CHK("alarm enable after reset", 1'b0, rd[7])
    end
    // unmapped and unaligned places
    wr(8'h40, 8'h55);
    `CHK("unmapped write response", `BCC_RESP_DECERR, resp)
    rdr(8'h05);
    `CHK("unaligned read response", `BCC_RESP_DECERR, resp)
    `CHK("unaligned read data", 32'h0, rd)
    // reserved bits read zero in every calendar counter and alarm
    for (int i = 0; i < 13; i++) begin
      wc(8'(4 * i + 4), 8'hff);
      rc(8'(4 * i + 4), MASKS[i], "readback mask");
    end
    for (int i = 7; i < 13; i++) begin
      wc(8'(4 * i + 4), 8'h00);
    end
    // carry chain through minutes, hours, weekday, date, month and year
    foreach (CAL[r]) begin
      wc(`BCC_OFF_RUN, 8'h08);
      for (int i = 0; i < 7; i++) begin
        wc(8'(4 * i + 4), CAL[r][i]);
      end
      wc(`BCC_OFF_RUN, 8'h0d);
      wc(`BCC_OFF_RUN, 8'h08);
      rc(`BCC_OFF_SEC, 8'h00, "seconds after adjust");
      rc(`BCC_OFF_DIV, 8'h00, "divider after adjust");
      for (int i = 1; i < 7; i++) begin
        rc(8'(4 * i + 4), CAL[r][i + 6], "calendar field after carry");
      end
    end
    // alarm compare with one enabled field unmatched, then disabled
    wc(`BCC_OFF_FLAG, 8'h08);
    wc(8'h24, 8'h81);
    wc(8'h20, 8'h80);
    rc(`BCC_OFF_FLAG, 8'h08, "alarm flag with unmatched field");
    wc(8'h24, 8'h01);
    rc(`BCC_OFF_FLAG, 8'h09, "alarm flag on match");
    `CHK("alarm request", 1'b1, alarmIrq)
    wc(`BCC_OFF_FLAG, 8'h09);
    rc(`BCC_OFF_FLAG, 8'h09, "alarm flag kept by write of one");
    wc(`BCC_OFF_FLAG, 8'h08);
    `CHK("alarm request cleared", 1'b0, alarmIrq)
    wc(`BCC_OFF_FLAG, 8'h90);
    `CHK("carry request", 1'b1, carryIrq)
    wc(`BCC_OFF_FLAG, 8'h08);
    `CHK("carry request cleared", 1'b0, carryIrq)
    // about 300 crystal ticks: one 64 Hz step
    wc(`BCC_OFF_RUN, 8'h0b);
    repeat (2600) @(posedge clock);
    wc(`BCC_OFF_RUN, 8'h08);
    rc(`BCC_OFF_DIV, 8'h01, "divider after one step");
    rc(`BCC_OFF_FLAG, 8'h88, "carry flag on divider step");
    repeat (1000) @(posedge clock);
    rc(`BCC_OFF_DIV, 8'h01, "divider while stopped");
    wc(`BCC_OFF_DIV, 8'hff);
    rc(`BCC_OFF_DIV, 8'h01, "divider after write");
    wc(`BCC_OFF_RUN, 8'h0a);
    rc(`BCC_OFF_DIV, 8'h00, "divider reset");
    // 1/256 s period is 128 crystal ticks
    wc(`BCC_OFF_RUN, 8'h19);
    repeat (1300) @(posedge clock);
    `CHK("periodic request", 1'b1, periodicIrq)
    wc(`BCC_OFF_RUN, 8'h18);
    `CHK("periodic request cleared", 1'b0, periodicIrq)
    for (int s = 0; s < 8; s++) begin
      wc(`BCC_OFF_RUN, {1'b0, 3'(s), 4'h8});
      rc(`BCC_OFF_RUN, {1'b0, 3'(s), 4'h8}, "period select");
    end
    // manual reset spares oscillator enable and start
    wc(`BCC_OFF_FLAG, 8'h18);
    wc(`BCC_OFF_RUN, 8'h78);
    manualReset <= 1'b1;
    @(posedge clock);
    manualReset <= 1'b0;
    rc(`BCC_OFF_FLAG, 8'h00, "flag control after manual reset");
    rc(`BCC_OFF_RUN, 8'h08, "run control after manual reset");
    rtcOutSelect <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("shared pin enable", 1'b1, pinOe)
    seen = 2'b00;
    repeat (10) begin
      @(posedge clock);
      seen = seen | {pinOut, ~pinOut};
    end
    `CHK("shared pin toggling", 2'b11, seen)
    // second power-on reset in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rc(`BCC_OFF_SEC, 8'h00, "seconds kept through reset");
    rc(`BCC_OFF_ALM_BASE, 8'h00, "seconds alarm after reset");
    rc(`BCC_OFF_RUN, `BCC_RUN_RESET, "run control after reset");
    giveVerdict();
  end
endmodule
